// ==== src/fdh_pkg.sv ====
package fdh_pkg;

  // Register indices on the holding-register port.
  localparam logic [15:0] ADDR_DRIVER_RESTART = 16'h0000;
  localparam logic [15:0] ADDR_SPEED_FLOOR = 16'h0001;
  localparam logic [15:0] ADDR_SPEED_CEILING = 16'h0002;

  // Reset values and field layout.
  localparam logic [15:0] RESTART_RESET = 16'h0000;
  localparam logic [15:0] RESTART_TRIGGER = 16'h0001;
  localparam logic [15:0] FLOOR_DEFAULT = 16'h0190;
  localparam logic [15:0] CEILING_DEFAULT = 16'h07d0;

  // Timing counts of the restart sequence, in clk_sys cycles.
  localparam int CLEAR_CYCLES = 2;
  localparam int RESTART_CYCLES = 1;

  typedef enum logic [1:0] {
    FDH_IDLE = 2'b00,
    FDH_CLEAR = 2'b01,
    FDH_START = 2'b11
  } fdh_state_t;

endpackage

// ==== src/fdh_holding_regs.sv ====
`timescale 1ns/1ps
module fdh_holding_regs #(
  parameter logic [15:0] FLOOR_DEFAULT = fdh_pkg::FLOOR_DEFAULT,
  parameter logic [15:0] CEILING_DEFAULT = fdh_pkg::CEILING_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  // Holding-register port from the protocol decoder
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_error,
  // Driver control
  output logic [15:0] speed_floor_rpm,
  output logic [15:0] speed_ceiling_rpm,
  output logic error_clear,
  output logic restart_fan,
  output logic restart_busy
);

  logic [15:0] restart_reg;
  logic [15:0] floor_reg;
  logic [15:0] ceiling_reg;
  fdh_pkg::fdh_state_t state_reg;
  logic [1:0] cnt_reg;
  logic trigger;

  // Only the value 1 triggers; other writes are dropped since the register holds 0 or 1.
  assign trigger = wr_en && addr == fdh_pkg::ADDR_DRIVER_RESTART && wr_data == fdh_pkg::RESTART_TRIGGER;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      // Model defaults are parameters, so the asynchronous reset still loads constants only.
      floor_reg <= FLOOR_DEFAULT;
      ceiling_reg <= CEILING_DEFAULT;
    end
    else if (clk_en)
    begin
      // Values are kept verbatim so a bad write shows on readback.
      if (wr_en && addr == fdh_pkg::ADDR_SPEED_FLOOR)
      begin
        floor_reg <= wr_data;
      end
      if (wr_en && addr == fdh_pkg::ADDR_SPEED_CEILING)
      begin
        ceiling_reg <= wr_data;
      end
    end
  end

  // Restart sequence: clear errors first, then restart the fan.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= fdh_pkg::FDH_IDLE;
      cnt_reg <= 2'h0;
      restart_reg <= fdh_pkg::RESTART_RESET;
    end
    else if (clk_en)
    begin
      case (state_reg)
        fdh_pkg::FDH_IDLE:
        begin
          if (trigger)
          begin
            state_reg <= fdh_pkg::FDH_CLEAR;
            cnt_reg <= 2'(fdh_pkg::CLEAR_CYCLES - 1);
            restart_reg <= fdh_pkg::RESTART_TRIGGER;
          end
        end
        fdh_pkg::FDH_CLEAR:
        begin
          if (cnt_reg == 2'h0)
          begin
            state_reg <= fdh_pkg::FDH_START;
            cnt_reg <= 2'(fdh_pkg::RESTART_CYCLES - 1);
          end
          else
          begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        fdh_pkg::FDH_START:
        begin
          if (cnt_reg == 2'h0)
          begin
            state_reg <= fdh_pkg::FDH_IDLE;
            restart_reg <= fdh_pkg::RESTART_RESET;
          end
          else
          begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        default:
        begin
          state_reg <= fdh_pkg::FDH_IDLE;
          restart_reg <= fdh_pkg::RESTART_RESET;
        end
      endcase
    end
  end

  // Registered outputs.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      error_clear <= 1'b0;
      restart_fan <= 1'b0;
      restart_busy <= 1'b0;
      speed_floor_rpm <= FLOOR_DEFAULT;
      speed_ceiling_rpm <= CEILING_DEFAULT;
    end
    else if (clk_en)
    begin
      error_clear <= state_reg == fdh_pkg::FDH_IDLE && trigger;
      restart_fan <= state_reg == fdh_pkg::FDH_CLEAR && cnt_reg == 2'h0;
      restart_busy <= restart_reg[0] || trigger;
      speed_floor_rpm <= floor_reg;
      speed_ceiling_rpm <= ceiling_reg;
    end
  end

  // Read port answers one cycle after rd_en; unknown indices report an error and zero.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      rd_error <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_valid <= rd_en;
      rd_error <= 1'b0;
      rd_data <= 16'h0000;
      if (rd_en)
      begin
        case (addr)
          fdh_pkg::ADDR_DRIVER_RESTART: rd_data <= restart_reg;
          fdh_pkg::ADDR_SPEED_FLOOR: rd_data <= floor_reg;
          fdh_pkg::ADDR_SPEED_CEILING: rd_data <= ceiling_reg;
          default: rd_error <= 1'b1;
        endcase
      end
    end
  end

  AST_RESTART_CLEARS_FIRST: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && state_reg == fdh_pkg::FDH_IDLE && trigger |=> error_clear && !restart_fan)
    else $error("Error clear did not follow restart trigger.");

  AST_RESTART_SELF_CLEARS: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && state_reg == fdh_pkg::FDH_IDLE && trigger ##1 clk_en [*4] |-> restart_reg == 16'h0000)
    else $error("Restart register did not return to zero.");

  AST_RESTART_SETS_ONE: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && state_reg == fdh_pkg::FDH_IDLE && trigger |=> restart_reg == 16'h0001)
    else $error("Restart register not set by trigger.");

  AST_RESTART_BINARY: assert property (@(posedge clk_sys) disable iff (!nrst)
    restart_reg[15:1] == 15'h0000)
    else $error("Restart register holds a value other than 0 or 1.");

  AST_FAN_AFTER_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(restart_fan) |-> !error_clear && $past(state_reg) == fdh_pkg::FDH_CLEAR)
    else $error("Fan restart not preceded by error clear.");

  AST_FLOOR_STORED: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && wr_en && addr == fdh_pkg::ADDR_SPEED_FLOOR |=> floor_reg == $past(wr_data))
    else $error("Floor register did not take the written value.");

  AST_CEILING_STORED: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && wr_en && addr == fdh_pkg::ADDR_SPEED_CEILING ##1 clk_en |=> speed_ceiling_rpm == $past(wr_data, 2))
    else $error("Ceiling output did not follow the write.");

  AST_READBACK_FLOOR: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && rd_en && addr == fdh_pkg::ADDR_SPEED_FLOOR |=> rd_valid && rd_data == $past(floor_reg))
    else $error("Floor readback mismatch.");

  AST_ERROR_CLEAR_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && error_clear |=> !error_clear)
    else $error("Error clear stood longer than one cycle.");

  AST_RESTART_FAN_PULSE: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && restart_fan |=> !restart_fan)
    else $error("Fan restart stood longer than one cycle.");

  AST_BUSY_DURING_SEQ: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg != fdh_pkg::FDH_IDLE |-> restart_busy)
    else $error("Busy low while the restart sequence runs.");

  AST_RESTART_ZERO_IDLE: assert property (@(posedge clk_sys) disable iff (!nrst)
    state_reg == fdh_pkg::FDH_IDLE |-> restart_reg == 16'h0000)
    else $error("Restart register nonzero while idle.");

  AST_UNMAPPED_READ: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en && rd_en && addr > fdh_pkg::ADDR_SPEED_CEILING |=> rd_valid && rd_error && rd_data == 16'h0000)
    else $error("Unmapped read did not report an error with zero data.");

  AST_FLOOR_OUT_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_en |=> speed_floor_rpm == $past(floor_reg))
    else $error("Floor output did not follow the register.");

endmodule

// ==== tb/fdh_master.sv ====
`timescale 1ns/1ps
module fdh_master (
  // Clock
  input wire logic clk_sys,
  // Holding-register port
  output logic wr_en,
  output logic rd_en,
  output logic [15:0] addr,
  output logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid
);
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 16'h0000;
    wr_data = 16'h0000;
  end
  // Each access holds its strobe for one cycle, then parks addr, and for a write also wr_data, at their complement.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys) #1;
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge clk_sys) #1;
    wr_en = 1'b0;
    addr = ~a;
    wr_data = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk_sys) #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk_sys) #1;
    rd_en = 1'b0;
    addr = ~a;
    ok = rd_valid;
    d = rd_data;
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic clk_sys;
  logic nrst;
  logic clk_en;
  logic rd_err;
  logic wr_en;
  logic rd_en;
  logic [15:0] addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic rd_valid;
  logic [15:0] floor_o;
  logic [15:0] ceil_o;
  logic error_clear;
  logic restart_fan;
  logic restart_busy;
  logic [15:0] d;
  logic ok;
  int mismatches;
  int n_compared;
  fdh_holding_regs dut_u (.clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .rd_error(rd_err),
    .speed_floor_rpm(floor_o), .speed_ceiling_rpm(ceil_o), .error_clear(error_clear),
    .restart_fan(restart_fan), .restart_busy(restart_busy));
  fdh_master m_u (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [15:0] a, input logic [15:0] e);
    m_u.rd(a, d, ok);
    chk({n, " valid"}, 16'h0001, {15'h0000, ok});
    chk(n, e, d);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial
  begin
    mismatches = 0;
    n_compared = 0;
    nrst = 1'b0;
    clk_en = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1 nrst = 1'b1;
    rdc("restart", fdh_pkg::ADDR_DRIVER_RESTART, 16'h0000);
    rdc("floor", fdh_pkg::ADDR_SPEED_FLOOR, fdh_pkg::FLOOR_DEFAULT);
    rdc("ceiling", fdh_pkg::ADDR_SPEED_CEILING, fdh_pkg::CEILING_DEFAULT);
    m_u.wr(fdh_pkg::ADDR_SPEED_FLOOR, 16'h012c);
    m_u.wr(fdh_pkg::ADDR_SPEED_CEILING, 16'h0640);
    chk("floor out", 16'h012c, floor_o);
    @(posedge clk_sys) #1;
    chk("ceiling out", 16'h0640, ceil_o);
    rdc("floor rd", fdh_pkg::ADDR_SPEED_FLOOR, 16'h012c);
    rdc("ceiling rd", fdh_pkg::ADDR_SPEED_CEILING, 16'h0640);
    m_u.wr(fdh_pkg::ADDR_SPEED_FLOOR, 16'h0000);
    rdc("floor unclamped", fdh_pkg::ADDR_SPEED_FLOOR, 16'h0000);
    m_u.wr(fdh_pkg::ADDR_SPEED_CEILING, 16'hffff);
    rdc("ceiling unclamped", fdh_pkg::ADDR_SPEED_CEILING, 16'hffff);
    clk_en = 1'b0;
    m_u.wr(fdh_pkg::ADDR_SPEED_FLOOR, 16'h0123);
    clk_en = 1'b1;
    rdc("floor frozen", fdh_pkg::ADDR_SPEED_FLOOR, 16'h0000);
    m_u.wr(fdh_pkg::ADDR_DRIVER_RESTART, 16'h0002);
    chk("busy idle", 16'h0000, {15'h0000, restart_busy});
    rdc("restart ignored", fdh_pkg::ADDR_DRIVER_RESTART, 16'h0000);
    m_u.wr(fdh_pkg::ADDR_DRIVER_RESTART, fdh_pkg::RESTART_TRIGGER);
    chk("error_clear", 16'h0001, {15'h0000, error_clear});
    chk("busy", 16'h0001, {15'h0000, restart_busy});
    @(posedge clk_sys) #1;
    chk("error_clear pulse", 16'h0000, {15'h0000, error_clear});
    chk("restart_fan early", 16'h0000, {15'h0000, restart_fan});
    @(posedge clk_sys) #1;
    chk("restart_fan", 16'h0001, {15'h0000, restart_fan});
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++)
    begin
      m_u.rd(fdh_pkg::ADDR_DRIVER_RESTART, d, ok);
      ok = ok && (d === 16'h0000);
    end
    chk("restart cleared", 16'h0001, {15'h0000, ok});
    if (!ok)
      end_sim();
    chk("restart_fan pulse", 16'h0000, {15'h0000, restart_fan});
    chk("busy done", 16'h0000, {15'h0000, restart_busy});
    m_u.rd(16'h0003, d, ok);
    chk("unmapped valid", 16'h0001, {15'h0000, ok});
    chk("unmapped error", 16'h0001, {15'h0000, rd_err});
    chk("unmapped data", 16'h0000, d);
    @(posedge clk_sys) #1;
    nrst = 1'b0;
    @(posedge clk_sys) #1;
    chk("floor out reset", fdh_pkg::FLOOR_DEFAULT, floor_o);
    chk("ceiling out reset", fdh_pkg::CEILING_DEFAULT, ceil_o);
    nrst = 1'b1;
    rdc("floor after reset", fdh_pkg::ADDR_SPEED_FLOOR, fdh_pkg::FLOOR_DEFAULT);
    rdc("ceiling after reset", fdh_pkg::ADDR_SPEED_CEILING, fdh_pkg::CEILING_DEFAULT);
    end_sim();
  end
endmodule
